// ==== src/smspi_front.v ====
// SPI slave front end of a byte-organised serial memory.
// Assumes link pins asynchronous to clk; array storage sits outside this block.
`timescale 1ns/10ps
`default_nettype none
`include "smspi_map.vh"

module smspi_front (
    input  wire                      clk,
    input  wire                      rst_n,
    input  wire                      cs_n_pin,
    input  wire                      sck_pin,
    input  wire                      si_pin,
    output reg                       so_out,
    output wire                      so_oe_n,
    output reg  [7:0]                opcode,
    output reg                       opcode_valid,
    output reg                       opcode_bad,
    output reg  [`SMSPI_ADDR_W-1:0]  mem_addr,
    output reg                       addr_valid,
    output reg  [7:0]                wr_data,
    output reg                       wr_strobe,
    output reg                       rd_strobe,
    input  wire [7:0]                rd_data,
    output reg                       mode3,
    output wire [7:0]                status
);

    // ==========================================================
    // Opcode decode
    function op_known;
        input [7:0] op;
        begin
            case (op)
                `SMSPI_OP_WREN, `SMSPI_OP_WRDI, `SMSPI_OP_RDSR, `SMSPI_OP_WRSR,
                `SMSPI_OP_WRITE, `SMSPI_OP_READ, `SMSPI_OP_FSTRD, `SMSPI_OP_SSWR,
                `SMSPI_OP_SSRD, `SMSPI_OP_RDID, `SMSPI_OP_RUID, `SMSPI_OP_WRSN,
                `SMSPI_OP_RDSN, `SMSPI_OP_DPD, `SMSPI_OP_HBN: op_known = 1'b1;
                default: op_known = 1'b0;
            endcase
        end
    endfunction

    function op_reads;
        input [7:0] op;
        begin
            op_reads = (op == `SMSPI_OP_READ) || (op == `SMSPI_OP_FSTRD) ||
                       (op == `SMSPI_OP_RDSR);
        end
    endfunction

    function op_addr;
        input [7:0] op;
        begin
            op_addr = (op == `SMSPI_OP_READ) || (op == `SMSPI_OP_FSTRD) ||
                      (op == `SMSPI_OP_WRITE);
        end
    endfunction

    // ==========================================================
    // Two-stage synchronisers; stage one feeds stage two only
    reg [2:0] sync1_reg;
    reg [2:0] sync2_reg;
    reg [2:0] prev_reg;
    always @(posedge clk) begin
        if (!rst_n) begin
            sync1_reg <= 3'h7;
            sync2_reg <= 3'h7;
            prev_reg  <= 3'h7;
        end else begin
            sync1_reg <= {cs_n_pin, sck_pin, si_pin};
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    wire cs_n   = sync2_reg[2];
    // Oversampling caps the link well below the 40 MHz clk; keep SCK under clk/6
    wire sck    = sync2_reg[1];
    wire si     = sync2_reg[0];
    wire cs_fall = prev_reg[2] & ~cs_n;
    wire sck_rise = ~prev_reg[1] & sck;
    wire sck_fall = prev_reg[1] & ~sck;

    // ==========================================================
    // Transaction state; a pure slave, it only reacts to select
    localparam ST_IDLE = 3'd0;
    localparam ST_OP   = 3'd1;
    localparam ST_ADDR = 3'd2;
    localparam ST_DATA = 3'd3;
    localparam ST_IGN  = 3'd4;

    reg [2:0] state_reg;
    reg [2:0] bit_cnt_reg;
    reg [1:0] byte_cnt_reg;
    reg [7:0] shift_reg;
    reg [7:0] tx_reg;
    reg       drive_reg;
    reg       armed_reg;
    reg       wel_reg;
    reg [7:0] sr_reg;
    wire [7:0] rx_byte = {shift_reg[6:0], si};

    // Status: bit 6 reads one, bits 0,4,5 zero, WEL shown live
    assign status  = (sr_reg & `SMSPI_SR_WMASK) | `SMSPI_SR_RST |
                     {6'h00, wel_reg, 1'b0};
    // Output enable is active low; drive only on read data
    assign so_oe_n = ~(drive_reg & ~cs_n);

    always @(posedge clk) begin
        if (!rst_n) begin
            state_reg    <= ST_IDLE;
            bit_cnt_reg  <= 3'd0;
            byte_cnt_reg <= 2'd0;
            shift_reg    <= 8'h00;
            tx_reg       <= 8'h00;
            drive_reg    <= 1'b0;
            armed_reg    <= 1'b0;
            wel_reg      <= 1'b0;
            sr_reg       <= `SMSPI_SR_RST;
            so_out       <= 1'b0;
            opcode       <= 8'h00;
            opcode_valid <= 1'b0;
            opcode_bad   <= 1'b0;
            mem_addr     <= {`SMSPI_ADDR_W{1'b0}};
            addr_valid   <= 1'b0;
            wr_data      <= 8'h00;
            wr_strobe    <= 1'b0;
            rd_strobe    <= 1'b0;
            mode3        <= 1'b0;
        end else begin
            opcode_valid <= 1'b0;
            opcode_bad   <= 1'b0;
            wr_strobe    <= 1'b0;
            rd_strobe    <= 1'b0;
            if (cs_n) begin
                // Deselect drops partial bytes and output; WEL clears after writes
                if (state_reg != ST_IDLE && (opcode == `SMSPI_OP_WRDI ||
                    opcode == `SMSPI_OP_WRSR || opcode == `SMSPI_OP_WRITE ||
                    opcode == `SMSPI_OP_SSWR || opcode == `SMSPI_OP_WRSN) &&
                    state_reg != ST_OP)
                    wel_reg <= 1'b0;
                state_reg  <= ST_IDLE;
                drive_reg  <= 1'b0;
                addr_valid <= 1'b0;
            end else if (cs_fall) begin
                // Clock level at select fall fixes mode for this frame
                mode3       <= sck;
                armed_reg   <= ~sck;
                state_reg   <= ST_OP;
                bit_cnt_reg <= 3'd0;
                byte_cnt_reg <= 2'd0;
            end else if (state_reg != ST_IDLE && state_reg != ST_IGN) begin
                // Mode 3: first fall only arms sampling
                if (sck_fall && !armed_reg)
                    armed_reg <= 1'b1;
                if (sck_rise && armed_reg) begin
                    shift_reg   <= rx_byte;
                    bit_cnt_reg <= bit_cnt_reg + 3'd1;
                    if (bit_cnt_reg == 3'd7) begin
                        case (state_reg)
                            ST_OP: begin
                                opcode <= rx_byte;
                                if (!op_known(rx_byte)) begin
                                    opcode_bad <= 1'b1;
                                    state_reg  <= ST_IGN;
                                end else begin
                                    opcode_valid <= 1'b1;
                                    if (rx_byte == `SMSPI_OP_WREN)
                                        wel_reg <= 1'b1;
                                    if (op_addr(rx_byte))
                                        state_reg <= ST_ADDR;
                                    else
                                        state_reg <= ST_DATA;
                                    if (rx_byte == `SMSPI_OP_RDSR) begin
                                        tx_reg    <= status;
                                        drive_reg <= 1'b1;
                                    end
                                end
                            end
                            ST_ADDR: begin
                                // Top six bits of the first byte are dropped
                                mem_addr <= {mem_addr[`SMSPI_ADDR_W-9:0], rx_byte};
                                byte_cnt_reg <= byte_cnt_reg + 2'd1;
                                if (byte_cnt_reg == 2'd2) begin
                                    state_reg  <= ST_DATA;
                                    addr_valid <= 1'b1;
                                    if (op_reads(opcode))
                                        rd_strobe <= 1'b1;
                                end
                            end
                            ST_DATA: begin
                                // Bytes land immediately, so no busy phase
                                if (opcode == `SMSPI_OP_WRITE && addr_valid) begin
                                    wr_data   <= rx_byte;
                                    wr_strobe <= wel_reg;
                                end else if (opcode == `SMSPI_OP_WRSR && wel_reg) begin
                                    sr_reg <= rx_byte;
                                end
                                if (op_reads(opcode) && addr_valid) begin
                                    rd_strobe <= 1'b1;
                                    mem_addr  <= mem_addr + 18'h0_0001;
                                end
                            end
                            default: state_reg <= ST_IGN;
                        endcase
                    end
                end
                // Read data appears after memory answers; load at byte boundary
                if (rd_strobe) begin
                    tx_reg    <= rd_data;
                    drive_reg <= 1'b1;
                end
                // Step write address only after the strobe, so address stands with data
                if (wr_strobe)
                    mem_addr <= mem_addr + 18'h0_0001;
                // Output bits change on falling clock, MSB first
                if (sck_fall && drive_reg) begin
                    so_out <= tx_reg[7];
                    tx_reg <= {tx_reg[6:0], tx_reg[7]};
                end
            end
        end
    end

endmodule // smspi_front
`default_nettype wire

// ==== src/smspi_map.vh ====
// Constants for the serial memory SPI slave front end.
// Assumes a 40 MHz system clock that oversamples the serial link pins.
// Functional notes
// - Memory space is 262,144 byte locations, each moved as eight serial bits.
// - Memory commands carry three address bytes; only the low 18 bits are used.
// - Opcode, address and data bytes all shift most significant bit first.
// - First whole byte after select falls is the opcode; address and data follow.
// - One opcode per select-low period; each command starts at a fresh select fall.
// - While deselected, serial input is ignored and serial output is high impedance.
// - Serial input is sampled on rising clock edges after select goes active.
// - Serial output data changes on falling clock edges.
// - Clock level at select fall picks mode 0 (low) or mode 3 (high).
// - In mode 3 the first falling edge is ignored; sampling starts at next rise.
// - Unknown opcode is dropped, rest ignored until next select fall, output off.
// - Writes complete during the transfer; no busy state, no ready polling.
// - Link runs well below the 40 MHz system clock; master must keep SCK under clk/6.
// - Device holds an eight-bit configuration and status register.
// - Decoder knows fifteen opcodes; every other value is invalid.
// - Device is a pure slave and never starts bus activity.
// - Serial output is driven only while returning read data.
`ifndef SMSPI_MAP_VH
`define SMSPI_MAP_VH

// ==========================================================
// Array geometry
`define SMSPI_ADDR_W      18
`define SMSPI_MEM_BYTES   262144
`define SMSPI_ADDR_BYTES  3

// ==========================================================
// Opcodes
`define SMSPI_OP_WREN  8'h06
`define SMSPI_OP_WRDI  8'h04
`define SMSPI_OP_RDSR  8'h05
`define SMSPI_OP_WRSR  8'h01
`define SMSPI_OP_WRITE 8'h02
`define SMSPI_OP_READ  8'h03
`define SMSPI_OP_FSTRD 8'h0B
`define SMSPI_OP_SSWR  8'h42
`define SMSPI_OP_SSRD  8'h4B
`define SMSPI_OP_RDID  8'h9F
`define SMSPI_OP_RUID  8'h4C
`define SMSPI_OP_WRSN  8'hC2
`define SMSPI_OP_RDSN  8'hC3
`define SMSPI_OP_DPD   8'hBA
`define SMSPI_OP_HBN   8'hB9

// ==========================================================
// Status register layout and reset value
`define SMSPI_SR_RST   8'h40
`define SMSPI_SR_WEL   1
`define SMSPI_SR_WMASK 8'h8C

`endif

// ==== tb/smspi_chk_sva.sv ====
// Port checker for the SPI slave front end.
// Assumes it is bound to smspi_front; pins are raw, asynchronous.
`timescale 1ns/10ps
`default_nettype none
`include "smspi_map.vh"
module smspi_chk (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       cs_n_pin,
    input wire logic       sck_pin,
    input wire logic       so_out,
    input wire logic       so_oe_n,
    input wire logic [7:0] opcode,
    input wire logic       opcode_valid,
    input wire logic       opcode_bad,
    input wire logic       addr_valid,
    input wire logic       wr_strobe,
    input wire logic       rd_strobe,
    input wire logic       mode3
);
    // ========
    // Known opcodes; the pins lag by a two-stage synchroniser
    function automatic logic known(input logic [7:0] op);
        return op inside {`SMSPI_OP_WREN, `SMSPI_OP_WRDI, `SMSPI_OP_RDSR, `SMSPI_OP_WRSR,
            `SMSPI_OP_WRITE, `SMSPI_OP_READ, `SMSPI_OP_FSTRD, `SMSPI_OP_SSWR, `SMSPI_OP_SSRD,
            `SMSPI_OP_RDID, `SMSPI_OP_RUID, `SMSPI_OP_WRSN, `SMSPI_OP_RDSN, `SMSPI_OP_DPD,
            `SMSPI_OP_HBN};
    endfunction
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_so_desel: assert property (cs_n_pin [*4] |-> so_oe_n)
        else $error("output driven while deselected");
    a_so_read: assert property (!so_oe_n |-> opcode inside {`SMSPI_OP_READ,
        `SMSPI_OP_FSTRD, `SMSPI_OP_RDSR}) else $error("output driven outside a read");
    a_valid_known: assert property (opcode_valid |-> known(opcode))
        else $error("valid pulse for unknown opcode");
    a_valid_excl: assert property (!(opcode_valid && opcode_bad))
        else $error("opcode both valid and bad");
    a_bad_quiet: assert property (opcode_bad |=> so_oe_n [*8])
        else $error("output enabled after bad opcode");
    a_one_op: assert property (opcode_valid |=> !opcode_valid [*8])
        else $error("second opcode too soon");
    a_wr_cause: assert property (wr_strobe |-> addr_valid && opcode == `SMSPI_OP_WRITE)
        else $error("write strobe without address");
    a_rd_cause: assert property (rd_strobe |-> addr_valid)
        else $error("read strobe before address");
    a_so_fall: assert property ($changed(so_out) && $past(!so_oe_n) && !cs_n_pin
        |-> !sck_pin) else $error("output changed outside clock low");
    a_mode_hold: assert property (!cs_n_pin && $past(!cs_n_pin, 4) |-> $stable(mode3))
        else $error("mode changed inside frame");
endmodule // smspi_chk
bind smspi_front smspi_chk u_chk (.clk(clk), .rst_n(rst_n), .cs_n_pin(cs_n_pin),
    .sck_pin(sck_pin), .so_out(so_out), .so_oe_n(so_oe_n), .opcode(opcode),
    .opcode_valid(opcode_valid), .opcode_bad(opcode_bad), .addr_valid(addr_valid),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .mode3(mode3));
`default_nettype wire

// ==== tb/smspi_mst.sv ====
// SPI master model driving the link pins at 5 MHz.
// Assumes the bench calls its tasks one frame at a time.
`timescale 1ns/10ps
`default_nettype none
module smspi_mst (
    output logic     cs_n,
    output logic     sck,
    output logic     si,
    input wire logic so
);
    logic m3;
    // ========
    // Idle: deselected, clock at rest
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        m3 = 1'b0;
    end
    // Rest level of the clock picks the mode
    task automatic start(input logic mode);
        m3 = mode;
        sck = mode;
        #150;
        cs_n = 1'b0;
        #100;
    endtask
    // Shifts n bits out and in; clock only runs inside frames
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        for (int i = 7; i > 7 - n; i--) begin
            if (m3) sck = 1'b0;
            si = tx[i];
            #100;
            sck = 1'b1;
            rx[i] = so;
            #100;
            if (!m3) sck = 1'b0;
        end
    endtask
    // Deselect; flip input so a stale level never passes as data
    task automatic stop();
        #100;
        cs_n = 1'b1;
        si = ~si;
        #300;
    endtask
endmodule // smspi_mst
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the SPI slave front end.
// Assumes the master model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
`include "smspi_map.vh"
module testbench;
    logic clk = 1'b0, rst_n = 1'b0, cs_n, sck, si, so_out, so_oe_n, opcode_valid, opcode_bad;
    logic addr_valid, wr_strobe, rd_strobe, mode3;
    logic [7:0] rd_data = 8'h00, opcode, wr_data, status, rx, wd;
    logic [17:0] mem_addr, wa;
    int n_errors = 0, compares = 0, n_ok = 0, n_bad = 0, n_wr = 0, cyc = 0;
    localparam logic [7:0] OPS [15] = '{8'h06, 8'h04, 8'h05, 8'h01, 8'h02, 8'h03, 8'h0B,
        8'h42, 8'h4B, 8'h9F, 8'h4C, 8'hC2, 8'hC3, 8'hBA, 8'hB9};
    always #12.5 clk = ~clk;
    // Released output shows the inverse, so a stale level is never read as data
    wire so_line = so_oe_n ? ~so_out : so_out;
    smspi_mst u_mst (.cs_n(cs_n), .sck(sck), .si(si), .so(so_line));
    smspi_front DUT (.clk(clk), .rst_n(rst_n), .cs_n_pin(cs_n), .sck_pin(sck), .si_pin(si),
        .so_out(so_out), .so_oe_n(so_oe_n), .opcode(opcode), .opcode_valid(opcode_valid),
        .opcode_bad(opcode_bad), .mem_addr(mem_addr), .addr_valid(addr_valid),
        .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
        .mode3(mode3), .status(status));
    // Array stand-in: byte is address-derived, so reads are predictable
    always @(negedge clk) if (rd_strobe === 1'b1) rd_data <= mem_addr[7:0] ^ 8'hA5;
    // Pulse counters and a hang limit
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (opcode_valid === 1'b1) n_ok <= n_ok + 1;
        if (opcode_bad === 1'b1) n_bad <= n_bad + 1;
        if (wr_strobe === 1'b1) begin
            n_wr <= n_wr + 1;
            wd <= wr_data;
            wa <= mem_addr;
        end
        if (cyc == 20000) begin
            n_errors++;
            end_sim();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic op1(input logic m, input logic [7:0] op);
        u_mst.start(m);
        u_mst.xfer(op, 8, rx);
        u_mst.stop();
    endtask
    // ========
    // Every known opcode, then two unknown ones
    task automatic t_ops();
        int k = n_ok;
        foreach (OPS[i]) begin
            op1(1'b0, OPS[i]);
            check(opcode, OPS[i]);
        end
        check(n_ok - k, 15);
        k = n_bad;
        op1(1'b1, 8'hFF);
        op1(1'b0, 8'h00);
        check(n_bad - k, 2);
        check(so_oe_n, 1'b1);
    endtask
    // Read with upper address bits set, two bytes streamed
    task automatic t_read(input logic m);
        u_mst.start(m);
        u_mst.xfer(`SMSPI_OP_READ, 8, rx);
        u_mst.xfer(8'hFE, 8, rx);
        u_mst.xfer(8'h12, 8, rx);
        u_mst.xfer(8'h34, 8, rx);
        check(mem_addr, 18'h2_1234);
        check(mode3, m);
        u_mst.xfer(8'h00, 8, rx);
        check(rx, 8'h91);
        u_mst.xfer(8'h00, 8, rx);
        check(rx, 8'h90);
        u_mst.stop();
    endtask
    // Enabled write, then one refused for lack of enable
    task automatic t_write();
        int k;
        op1(1'b1, `SMSPI_OP_WREN);
        check(status[1], 1'b1);
        k = n_wr;
        for (int w = 0; w < 2; w++) begin
            u_mst.start(w[0]);
            u_mst.xfer(`SMSPI_OP_WRITE, 8, rx);
            repeat (2) u_mst.xfer(8'h00, 8, rx);
            u_mst.xfer(8'h07, 8, rx);
            u_mst.xfer(8'hC3, 8, rx);
            u_mst.stop();
        end
        check(n_wr - k, 1);
        check({wa, wd}, {18'h0_0007, 8'hC3});
        check(status, 8'h40);
    endtask
    // Frame cut mid-opcode, then a status read must still work
    task automatic t_abort();
        int k = n_ok;
        u_mst.start(1'b0);
        u_mst.xfer(`SMSPI_OP_RDSR, 4, rx);
        u_mst.stop();
        check(n_ok, k);
        u_mst.start(1'b0);
        u_mst.xfer(`SMSPI_OP_RDSR, 8, rx);
        u_mst.xfer(8'h00, 8, rx);
        check(rx, 8'h40);
        u_mst.stop();
    endtask
    task automatic end_sim();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Reset, settle, then the scenarios
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_ops();
        t_read(1'b0);
        t_read(1'b1);
        t_write();
        t_abort();
        end_sim();
    end
endmodule // testbench
`default_nettype wire
